/* hdl/evt_defs.svh */
// Offsets, field positions, reset values and timing constants of the egress tagging and rate registers.
`ifndef EVT_DEFS_SVH
`define EVT_DEFS_SVH

// Register indices; the byte address is four times the index.
`define EVT_IDX_TAG 14'h1c0c
`define EVT_IDX_HQ01 14'h1c0d
`define EVT_IDX_HQ23 14'h1c0e
`define EVT_IDX_P1Q01 14'h1c0f

// Tagging field layout: port p starts at bit p times the stride.
`define EVT_PORT_STRIDE 8
`define EVT_TYPE_OFS 0
`define EVT_CHG_TAG_OFS 2
`define EVT_CHG_PRIO_OFS 3
`define EVT_CHG_VID_OFS 4
`define EVT_INSERT_OFS 5
`define EVT_TAG_MASK 32'h003f3f3f

// Rate field layout: even queue low, odd queue high.
`define EVT_RATE_LO_LSB 0
`define EVT_RATE_HI_LSB 13
`define EVT_RATE_MASK 32'h03ffffff

// Reset values.
`define EVT_TAG_RESET 32'h00000000
`define EVT_RATE_RESET 32'h00000000

// One rate unit is 20 ns per byte at a 5 ns clock period.
`define EVT_UNIT_NS 20
`define EVT_CLK_PERIOD_NS 5
`define EVT_UNIT_CYCLES ((`EVT_UNIT_NS + `EVT_CLK_PERIOD_NS - 1) / `EVT_CLK_PERIOD_NS)

`endif

/* hdl/evt_pkg.sv */
// Types shared by the egress tagging and rate register block.
package evt_pkg;

  // Egress port type codes.
  typedef enum logic [1:0] {
    EVT_TYPE_DUMB = 2'b00,
    EVT_TYPE_ACCESS = 2'b01,
    EVT_TYPE_HYBRID = 2'b10,
    EVT_TYPE_CPU = 2'b11
  } evt_port_type_t;

  // Tag state of a packet as it arrives at egress.
  typedef enum logic [1:0] {
    EVT_PKT_UNTAGGED = 2'b00,
    EVT_PKT_PRIO_TAGGED = 2'b01,
    EVT_PKT_REG_TAGGED = 2'b10,
    EVT_PKT_SPECIAL = 2'b11
  } evt_pkt_tag_t;

  // What egress does to the tag.
  typedef enum logic [2:0] {
    EVT_ACT_PASS = 3'b000,
    EVT_ACT_STRIP = 3'b001,
    EVT_ACT_INSERT = 3'b010,
    EVT_ACT_MODIFY = 3'b011,
    EVT_ACT_SPECIAL = 3'b100
  } evt_action_t;

  // Default VLAN ID and priority of one port.
  typedef struct packed {
    logic [2:0] prio;
    logic [11:0] vid;
  } evt_vlan_dflt_t;

  // One egress tagging decision request.
  typedef struct packed {
    evt_pkt_tag_t tag;
    logic [1:0] ingress;
    logic [1:0] egress;
    logic [11:0] vid;
    logic [2:0] prio;
    logic untag_dflt;
    logic untag_in;
  } evt_tag_req_t;

  // The resulting tag for the egressing packet.
  typedef struct packed {
    evt_action_t action;
    logic [11:0] vid;
    logic [2:0] prio;
    logic [1:0] src_port;
  } evt_tag_res_t;

endpackage : evt_pkg

/* hdl/evt_pacer.sv */
// Per-queue byte pacer that holds off the next byte for the programmed interval.
`timescale 1ns/1ps
`include "evt_defs.svh"

module evt_pacer #(
  parameter int RATE_W = 13,
  parameter int UNIT_CYCLES = `EVT_UNIT_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Programmed rate field.
  input wire logic [RATE_W-1:0] rate,
  // Byte handshake from the queue.
  input wire logic byte_valid,
  output logic byte_ready
);

  localparam int CNT_W = RATE_W + 6;

  logic [CNT_W-1:0] wait_cnt;
  logic [CNT_W-1:0] next_wait;

  // Interval is (rate + 1) units, less the cycle in which the byte leaves.
  assign next_wait = CNT_W'((CNT_W'(rate) + CNT_W'(1)) * CNT_W'(UNIT_CYCLES) - CNT_W'(1));

  // A queue may send only once the previous interval has run out.
  assign byte_ready = (wait_cnt == '0);

  // The rate is sampled at the byte, so a rewrite only affects the next interval.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wait_cnt <= '0;
    else if (byte_valid && byte_ready)
      wait_cnt <= next_wait;
    else if (wait_cnt != '0)
      wait_cnt <= wait_cnt - CNT_W'(1);
  end

  // Bytes are spaced by the interval armed at the previous byte, so a rate rewrite
  // between two bytes does not move the bound that the check applies.
  logic [CNT_W-1:0] gap;
  logic [CNT_W-1:0] last_wait;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gap <= '1;
      last_wait <= '0;
    end
    else if (byte_valid && byte_ready)
    begin
      gap <= CNT_W'(1);
      last_wait <= next_wait;
    end
    else if (gap != '1)
      gap <= gap + CNT_W'(1);
  end

  byte_spacing_a: assert property (@(posedge clk) disable iff (rst)
    (byte_valid && byte_ready && gap != '1) |-> (gap > last_wait))
    else $error("pacer released a byte early");

  minimum_gap_a: assert property (@(posedge clk) disable iff (rst)
    (byte_valid && byte_ready) |=> !byte_ready [*3])
    else $error("pacer gap shorter than one rate unit");

endmodule : evt_pacer

/* hdl/evt_regs.sv */
// Egress tagging rules and egress rate registers with APB access, tag decision and per-queue pacing.
// Behaviour
// - Each port has a two-bit egress port type at bits 17:16 (port 2), 9:8 (port 1) and 1:0 (host).
// - Type 00 passes packets from regular ports untouched and strips the special tag of host packets.
// - Type 01 strips every tag, including special tags from the host port.
// - Type 10 inserts, strips or changes tags according to the port's four enables; special tags are always stripped and priority tags always get the ingress VID.
// - Type 11 adds a special tag naming the port the packet was received on.
// - Port 1 keeps insert, change-VID, change-priority and change-tag at bits 13, 12, 11 and 10.
// - The host port keeps insert, change-VID, change-priority and change-tag at bits 5, 4, 3 and 2.
// - Each queue has a 13-bit rate field, odd queue at bits 25:13, even queue at bits 12:0.
// - A rate field means a time per byte of the field value plus one, times 20 ns.
// - Host queues 0/1 sit in one register and queues 2/3 in the next, queue 3 in the upper field.
// - Port 1 queues 0/1 sit in the register after the host queue 2/3 register, same layout.
// - Hybrid insert tags untagged packets with the ingress defaults if the default VID's un-tag bit is clear.
// - Hybrid change-VID with change-tag replaces a regular tag's VID with the egress default VID, or strips it.
// - Hybrid change-priority sets the egress default priority; priority-tagged packets get the ingress VID.
// - Change-tag gates change-VID and change-priority for regular tags and does nothing for priority tags.
`timescale 1ns/1ps
`include "evt_defs.svh"

module evt_regs #(
  parameter int RATE_W = 13,
  parameter int UNIT_CYCLES = `EVT_UNIT_CYCLES,
  parameter int NUM_QUEUES = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Default VLAN settings of host, port 1 and port 2.
  input wire evt_pkg::evt_vlan_dflt_t [2:0] vlan_dflt,
  // Tag decision request and result.
  input wire logic tag_req_valid,
  input wire evt_pkg::evt_tag_req_t tag_req,
  output logic tag_res_valid,
  output evt_pkg::evt_tag_res_t tag_res,
  // Byte handshakes: host queues 0..3, then port 1 queues 0..1.
  input wire logic [NUM_QUEUES-1:0] byte_valid,
  output logic [NUM_QUEUES-1:0] byte_ready
);

  logic [31:0] tag_rules;
  logic [31:0] host_q01;
  logic [31:0] host_q23;
  logic [31:0] p1_q01;

  // Byte address of a register index.
  function automatic logic [15:0] addr_of(input logic [13:0] idx);
    addr_of = {idx, 2'b00};
  endfunction : addr_of

  logic wr_en;
  logic setup;
  logic hit_tag;
  logic hit_hq01;
  logic hit_hq23;
  logic hit_p1q01;
  logic hit_any;

  // Address decode, shared by both phases.
  assign hit_tag = (paddr == addr_of(`EVT_IDX_TAG));
  assign hit_hq01 = (paddr == addr_of(`EVT_IDX_HQ01));
  assign hit_hq23 = (paddr == addr_of(`EVT_IDX_HQ23));
  assign hit_p1q01 = (paddr == addr_of(`EVT_IDX_P1Q01));
  assign hit_any = hit_tag | hit_hq01 | hit_hq23 | hit_p1q01;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && hit_any;

  // Zero wait states: read data is already captured in the setup cycle.
  assign pready = 1'b1;

  // Tagging rules register; reserved bits never store.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tag_rules <= `EVT_TAG_RESET;
    else if (wr_en && hit_tag)
      tag_rules <= pwdata & `EVT_TAG_MASK;
  end

  // Host queue rate registers.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      host_q01 <= `EVT_RATE_RESET;
      host_q23 <= `EVT_RATE_RESET;
    end
    else if (wr_en)
    begin
      if (hit_hq01)
        host_q01 <= pwdata & `EVT_RATE_MASK;
      if (hit_hq23)
        host_q23 <= pwdata & `EVT_RATE_MASK;
    end
  end

  // Port 1 queue 0/1 rate register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      p1_q01 <= `EVT_RATE_RESET;
    else if (wr_en && hit_p1q01)
      p1_q01 <= pwdata & `EVT_RATE_MASK;
  end

  // Read data and error are taken in the setup cycle and held through the access phase.
  // Unmapped addresses answer with an error and zero data; writes to them are dropped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !hit_any;
      prdata <= 32'h00000000;
      if (!pwrite)
      begin
        if (hit_tag)
          prdata <= tag_rules;
        else if (hit_hq01)
          prdata <= host_q01;
        else if (hit_hq23)
          prdata <= host_q23;
        else if (hit_p1q01)
          prdata <= p1_q01;
      end
    end
  end

  // Rate fields per queue, even queue low and odd queue high.
  logic [NUM_QUEUES-1:0][RATE_W-1:0] rate;
  assign rate[0] = host_q01[`EVT_RATE_LO_LSB +: RATE_W];
  assign rate[1] = host_q01[`EVT_RATE_HI_LSB +: RATE_W];
  assign rate[2] = host_q23[`EVT_RATE_LO_LSB +: RATE_W];
  assign rate[3] = host_q23[`EVT_RATE_HI_LSB +: RATE_W];
  assign rate[4] = p1_q01[`EVT_RATE_LO_LSB +: RATE_W];
  assign rate[5] = p1_q01[`EVT_RATE_HI_LSB +: RATE_W];

  // One pacer per queue.
  genvar q;
  generate
    for (q = 0; q < NUM_QUEUES; q++)
    begin : g_pacer
      evt_pacer #(
        .RATE_W(RATE_W),
        .UNIT_CYCLES(UNIT_CYCLES)
      ) u_pacer (
        .clk(clk),
        .rst(rst),
        .rate(rate[q]),
        .byte_valid(byte_valid[q]),
        .byte_ready(byte_ready[q])
      );
    end
  endgenerate

  // Per-port fields of the egress port being decided.
  evt_pkg::evt_port_type_t eg_type;
  logic en_insert;
  logic en_chg_vid;
  logic en_chg_prio;
  logic en_chg_tag;
  logic [4:0] lsb;

  // Port 2 stride lands on bit 16, port 1 on 8, host on 0; a port code of 3 reads as host.
  assign lsb = (tag_req.egress == 2'b11) ? 5'h00 : 5'(tag_req.egress * `EVT_PORT_STRIDE);
  assign eg_type = evt_pkg::evt_port_type_t'(tag_rules[lsb + 5'(`EVT_TYPE_OFS) +: 2]);
  assign en_insert = tag_rules[lsb + 5'(`EVT_INSERT_OFS)];
  assign en_chg_vid = tag_rules[lsb + 5'(`EVT_CHG_VID_OFS)];
  assign en_chg_prio = tag_rules[lsb + 5'(`EVT_CHG_PRIO_OFS)];
  assign en_chg_tag = tag_rules[lsb + 5'(`EVT_CHG_TAG_OFS)];

  evt_pkg::evt_vlan_dflt_t in_dflt;
  evt_pkg::evt_vlan_dflt_t eg_dflt;
  assign in_dflt = (tag_req.ingress == 2'b11) ? vlan_dflt[0] : vlan_dflt[tag_req.ingress];
  assign eg_dflt = (tag_req.egress == 2'b11) ? vlan_dflt[0] : vlan_dflt[tag_req.egress];

  // Tag decision for one packet.
  evt_pkg::evt_tag_res_t next_res;
  always_comb
  begin
    next_res.action = evt_pkg::EVT_ACT_PASS;
    next_res.vid = tag_req.vid;
    next_res.prio = tag_req.prio;
    next_res.src_port = tag_req.ingress;
    unique case (eg_type)
      evt_pkg::EVT_TYPE_DUMB:
      begin
        if (tag_req.tag == evt_pkg::EVT_PKT_SPECIAL)
          next_res.action = evt_pkg::EVT_ACT_STRIP;
      end
      evt_pkg::EVT_TYPE_ACCESS:
      begin
        if (tag_req.tag != evt_pkg::EVT_PKT_UNTAGGED)
          next_res.action = evt_pkg::EVT_ACT_STRIP;
      end
      evt_pkg::EVT_TYPE_HYBRID:
      begin
        unique case (tag_req.tag)
          evt_pkg::EVT_PKT_UNTAGGED:
          begin
            if (en_insert && !tag_req.untag_dflt)
            begin
              next_res.action = evt_pkg::EVT_ACT_INSERT;
              next_res.vid = in_dflt.vid;
              next_res.prio = in_dflt.prio;
            end
          end
          evt_pkg::EVT_PKT_PRIO_TAGGED:
          begin
            // Change-tag is ignored here on purpose.
            next_res.action = evt_pkg::EVT_ACT_MODIFY;
            next_res.vid = in_dflt.vid;
            if (en_chg_prio)
              next_res.prio = eg_dflt.prio;
          end
          evt_pkg::EVT_PKT_REG_TAGGED:
          begin
            if (en_chg_tag && (en_chg_vid || en_chg_prio))
            begin
              if (tag_req.untag_in)
                next_res.action = evt_pkg::EVT_ACT_STRIP;
              else
              begin
                next_res.action = evt_pkg::EVT_ACT_MODIFY;
                if (en_chg_vid)
                  next_res.vid = eg_dflt.vid;
                if (en_chg_prio)
                  next_res.prio = eg_dflt.prio;
              end
            end
          end
          evt_pkg::EVT_PKT_SPECIAL:
            next_res.action = evt_pkg::EVT_ACT_STRIP;
        endcase
      end
      evt_pkg::EVT_TYPE_CPU:
        next_res.action = evt_pkg::EVT_ACT_SPECIAL;
    endcase
  end

  // Decision result registered, one cycle after the request.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tag_res_valid <= 1'b0;
      tag_res <= '0;
    end
    else
    begin
      tag_res_valid <= tag_req_valid;
      if (tag_req_valid)
        tag_res <= next_res;
    end
  end

  // Checks on the decision path.
  cpu_special_tag_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_CPU) |=>
      (tag_res.action == evt_pkg::EVT_ACT_SPECIAL && tag_res.src_port == $past(tag_req.ingress)))
    else $error("cpu type did not add a special tag");

  dumb_pass_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_DUMB && tag_req.tag != evt_pkg::EVT_PKT_SPECIAL)
      |=> tag_res.action == evt_pkg::EVT_ACT_PASS)
    else $error("dumb type changed a regular packet");

  access_strip_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_ACCESS && tag_req.tag != evt_pkg::EVT_PKT_UNTAGGED)
      |=> tag_res.action == evt_pkg::EVT_ACT_STRIP)
    else $error("access type kept a tag");

  hybrid_insert_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_HYBRID && tag_req.tag == evt_pkg::EVT_PKT_UNTAGGED)
      |=> ((tag_res.action == evt_pkg::EVT_ACT_INSERT) == $past(en_insert && !tag_req.untag_dflt)))
    else $error("hybrid insert wrong");

  change_gate_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_HYBRID && tag_req.tag == evt_pkg::EVT_PKT_REG_TAGGED
      && !en_chg_tag) |=> tag_res.action == evt_pkg::EVT_ACT_PASS)
    else $error("regular tag changed without change-tag");

  vid_replace_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_HYBRID && tag_req.tag == evt_pkg::EVT_PKT_REG_TAGGED
      && en_chg_tag && en_chg_vid && !tag_req.untag_in) |=> tag_res.vid == $past(eg_dflt.vid))
    else $error("vid not replaced by egress default");

  prio_tag_vid_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_HYBRID && tag_req.tag == evt_pkg::EVT_PKT_PRIO_TAGGED)
      |=> tag_res.vid == $past(in_dflt.vid))
    else $error("priority tag did not get ingress default vid");

  prio_replace_a: assert property (@(posedge clk) disable iff (rst)
    (tag_req_valid && eg_type == evt_pkg::EVT_TYPE_HYBRID && tag_req.tag == evt_pkg::EVT_PKT_REG_TAGGED
      && en_chg_tag && en_chg_prio && !tag_req.untag_in) |=> tag_res.prio == $past(eg_dflt.prio))
    else $error("priority not replaced by egress default");

  // Every request gets exactly one result, one clock later.
  result_valid_a: assert property (@(posedge clk) disable iff (rst)
    tag_req_valid |=> tag_res_valid)
    else $error("decision result missing");

  // Checks on the register file.
  tag_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && hit_tag) |=> (tag_rules == ($past(pwdata) & `EVT_TAG_MASK)) && tag_rules[31:22] == 10'h000)
    else $error("tagging register write lost or reserved bits stored");

  rate_field_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && hit_hq01) |=> rate[1] == $past(pwdata[25:13]) && rate[0] == $past(pwdata[12:0]))
    else $error("rate field layout wrong");

  readback_a: assert property (@(posedge clk) disable iff (rst)
    (setup && !pwrite && hit_p1q01) |=> prdata == $past(p1_q01) && !pslverr)
    else $error("port 1 rate read back wrong");

  unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
    (setup && !hit_any) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  // Main scenarios.
  hybrid_modify_c: cover property (@(posedge clk) disable iff (rst)
    tag_res_valid && tag_res.action == evt_pkg::EVT_ACT_MODIFY);
  insert_c: cover property (@(posedge clk) disable iff (rst)
    tag_res_valid && tag_res.action == evt_pkg::EVT_ACT_INSERT);
  paced_byte_c: cover property (@(posedge clk) disable iff (rst)
    byte_valid[4] && !byte_ready[4] ##[1:64] byte_ready[4]);
  rate_write_c: cover property (@(posedge clk) disable iff (rst) wr_en && hit_hq23);

endmodule : evt_regs

/* dv/tb_top.sv */
// Self-checking testbench for the egress tagging and rate register block.
`timescale 1ns/1ps
`include "evt_defs.svh"

module tb_top;
  // Byte addresses of the four registers and of the unmapped neighbour after them.
  localparam logic [15:0] A_TAG = {`EVT_IDX_TAG, 2'b00};
  localparam logic [15:0] A_HQ01 = {`EVT_IDX_HQ01, 2'b00};
  localparam logic [15:0] A_HQ23 = {`EVT_IDX_HQ23, 2'b00};
  localparam logic [15:0] A_P1Q01 = {`EVT_IDX_P1Q01, 2'b00};
  localparam logic [15:0] A_NONE = 16'h7040;
  localparam int LIMIT = 5000;

  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  evt_pkg::evt_vlan_dflt_t [2:0] vlan_dflt;
  logic tag_req_valid;
  evt_pkg::evt_tag_req_t tag_req;
  logic tag_res_valid;
  evt_pkg::evt_tag_res_t tag_res;
  logic [5:0] byte_valid;
  logic [5:0] byte_ready;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  evt_regs evt_regs_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vlan_dflt(vlan_dflt), .tag_req_valid(tag_req_valid), .tag_req(tag_req),
    .tag_res_valid(tag_res_valid), .tag_res(tag_res), .byte_valid(byte_valid), .byte_ready(byte_ready));

  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hung run short; the limit leaves ample room for every scenario.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      results();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Compares one value with its expectation; case inequality so unknowns never match.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Sends one tag decision request and judges the registered result and its one-cycle pulse.
  task automatic tag(input evt_pkg::evt_pkt_tag_t kind, input logic [1:0] ing, input logic [1:0] egr,
                     input logic [1:0] untag, input evt_pkg::evt_action_t act, input logic [14:0] vp);
    @(posedge clk);
    tag_req_valid <= 1'b1;
    tag_req <= '{tag: kind, ingress: ing, egress: egr, vid: 12'h5a5, prio: 3'h6,
                 untag_dflt: untag[1], untag_in: untag[0]};
    @(posedge clk);
    tag_req_valid <= 1'b0;
    #1;
    chk("result valid", {31'h0, tag_res_valid}, 32'h1);
    chk("action", {29'h0, tag_res.action}, {29'h0, act});
    if (act == evt_pkg::EVT_ACT_INSERT || act == evt_pkg::EVT_ACT_MODIFY)
      chk("prio and vid", {17'h0, tag_res.prio, tag_res.vid}, {17'h0, vp});
    if (act == evt_pkg::EVT_ACT_SPECIAL)
      chk("source port", {30'h0, tag_res.src_port}, {30'h0, ing});
    @(posedge clk);
    #1;
    chk("result pulse end", {31'h0, tag_res_valid}, 32'h0);
  endtask : tag

  // Holds a byte request on one queue and measures the edges between two accepted bytes.
  task automatic pace(input int q, input int rate);
    int n;
    @(posedge clk);
    byte_valid[q] <= 1'b1;
    @(posedge clk);
    while (byte_ready[q] !== 1'b1)
      @(posedge clk);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (byte_ready[q] !== 1'b1 && n < 200);
    byte_valid[q] <= 1'b0;
    // One rate unit is 20 ns, four cycles of the 5 ns clock.
    chk("byte interval", n, (rate + 1) * 20 / 5);
  endtask : pace

  // Reset values, writable bits and the unmapped neighbour.
  task automatic check_regs();
    logic [15:0] addrs [4];
    logic [31:0] masks [4];
    addrs = '{A_TAG, A_HQ01, A_HQ23, A_P1Q01};
    // Tagging bits 21:16, 13:8, 5:0; rate bits 25:0; all else reads zero.
    masks = '{32'h003f3f3f, 32'h03ffffff, 32'h03ffffff, 32'h03ffffff};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, addrs[i], 32'h0);
      chk("reset value", rd, 32'h0);
      chk("error on mapped read", {31'h0, err}, 32'h0);
      apb(1'b1, addrs[i], 32'hffffffff);
      apb(1'b0, addrs[i], 32'h0);
      chk("writable bits", rd, masks[i]);
    end
    apb(1'b1, A_NONE, 32'hffffffff);
    chk("error on unmapped write", {31'h0, err}, 32'h1);
    apb(1'b0, A_NONE, 32'h0);
    chk("error on unmapped read", {31'h0, err}, 32'h1);
    chk("unmapped read data", rd, 32'h0);
  endtask : check_regs

  // Pass-through, strip and special-tag port types.
  task automatic check_fixed_types();
    // Port 2 pass-through, port 1 strip, host special tag.
    apb(1'b1, A_TAG, 32'h00000103);
    tag(evt_pkg::EVT_PKT_SPECIAL, 2'd0, 2'd2, 2'b00, evt_pkg::EVT_ACT_STRIP, 15'h0);
    tag(evt_pkg::EVT_PKT_REG_TAGGED, 2'd1, 2'd2, 2'b00, evt_pkg::EVT_ACT_PASS, 15'h0);
    tag(evt_pkg::EVT_PKT_REG_TAGGED, 2'd2, 2'd1, 2'b00, evt_pkg::EVT_ACT_STRIP, 15'h0);
    tag(evt_pkg::EVT_PKT_SPECIAL, 2'd0, 2'd1, 2'b00, evt_pkg::EVT_ACT_STRIP, 15'h0);
    tag(evt_pkg::EVT_PKT_UNTAGGED, 2'd2, 2'd0, 2'b00, evt_pkg::EVT_ACT_SPECIAL, 15'h0);
  endtask : check_fixed_types

  // Hybrid ports with different enable sets on each port.
  task automatic check_hybrid();
    // Port 2: insert, change VID, change tag; port 1: change VID alone; host: change prio and tag.
    apb(1'b1, A_TAG, 32'h0036120e);
    tag(evt_pkg::EVT_PKT_UNTAGGED, 2'd1, 2'd2, 2'b00, evt_pkg::EVT_ACT_INSERT, 15'h2122);
    tag(evt_pkg::EVT_PKT_UNTAGGED, 2'd1, 2'd2, 2'b10, evt_pkg::EVT_ACT_PASS, 15'h0);
    tag(evt_pkg::EVT_PKT_REG_TAGGED, 2'd0, 2'd2, 2'b00, evt_pkg::EVT_ACT_MODIFY, 15'h6233);
    tag(evt_pkg::EVT_PKT_REG_TAGGED, 2'd0, 2'd2, 2'b01, evt_pkg::EVT_ACT_STRIP, 15'h0);
    tag(evt_pkg::EVT_PKT_REG_TAGGED, 2'd2, 2'd1, 2'b00, evt_pkg::EVT_ACT_PASS, 15'h0);
    tag(evt_pkg::EVT_PKT_PRIO_TAGGED, 2'd2, 2'd1, 2'b00, evt_pkg::EVT_ACT_MODIFY, 15'h6233);
    tag(evt_pkg::EVT_PKT_REG_TAGGED, 2'd1, 2'd0, 2'b00, evt_pkg::EVT_ACT_MODIFY, 15'h15a5);
    tag(evt_pkg::EVT_PKT_PRIO_TAGGED, 2'd1, 2'd0, 2'b00, evt_pkg::EVT_ACT_MODIFY, 15'h1122);
  endtask : check_hybrid

  // Distinct rates on queues 0, 3, 4 and 5 show which field paces each of them.
  task automatic check_pacing();
    apb(1'b1, A_HQ01, 32'h00000003);
    apb(1'b1, A_HQ23, 32'h00002000);
    apb(1'b1, A_P1Q01, 32'h00004005);
    apb(1'b0, A_P1Q01, 32'h0);
    chk("port 1 rates", rd, 32'h00004005);
    pace(0, 3);
    pace(3, 1);
    pace(4, 5);
    pace(5, 2);
  endtask : check_pacing

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    vlan_dflt = {15'h3233, 15'h2122, 15'h1011};
    tag_req_valid = 1'b0;
    tag_req = '0;
    byte_valid = 6'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check_regs();
    check_fixed_types();
    check_hybrid();
    check_pacing();
    results();
  end
endmodule : tb_top
